//--- hdl/gpib_rl_pkg.sv
package gpib_rl_pkg;
  // Register byte offsets
  localparam logic [7:0] CFG_OFS      = 8'h00;
  localparam logic [7:0] STAT_OFS     = 8'h04;
  // CONFIG fields
  localparam int         CFG_ADDR_LSB = 0;
  localparam int         CFG_SET_BIT  = 8;
  localparam logic [4:0] ADDR_RST     = 5'h01;
  localparam logic [4:0] ADDR_MAX     = 5'h1e;
  localparam logic       SET_RST      = 1'b0;
  // STATUS fields
  localparam int         ST_REMOTE    = 0;
  localparam int         ST_LOCKOUT   = 1;
  localparam int         ST_LISTEN    = 2;
  localparam int         ST_TALK      = 3;
  localparam int         ST_SPOLL     = 4;
  localparam int         ST_LEGACY    = 5;
  localparam int         ST_PENDING   = 6;
  // Bus command bytes, seven bits, sent with attention true
  localparam logic [6:0] CMD_GTL      = 7'h01;
  localparam logic [6:0] CMD_SDC      = 7'h04;
  localparam logic [6:0] CMD_PPC      = 7'h05;
  localparam logic [6:0] CMD_GET      = 7'h08;
  localparam logic [6:0] CMD_TCT      = 7'h09;
  localparam logic [6:0] CMD_LLO      = 7'h11;
  localparam logic [6:0] CMD_DCL      = 7'h14;
  localparam logic [6:0] CMD_PPU      = 7'h15;
  localparam logic [6:0] CMD_SPE      = 7'h18;
  localparam logic [6:0] CMD_SPD      = 7'h19;
  localparam logic [6:0] CMD_UNL      = 7'h3f;
  localparam logic [6:0] CMD_UNT      = 7'h5f;
  localparam logic [1:0] GRP_LISTEN   = 2'h1;
  localparam logic [1:0] GRP_TALK     = 2'h2;
  // Cycles after reset release before the stored set is sampled
  localparam logic [1:0] BOOT_DONE    = 2'h3;

  typedef enum logic [1:0] {
    NET_REM_ON   = 2'h0,
    NET_REM_OFF  = 2'h1,
    NET_LOCK_ON  = 2'h2,
    NET_LOCK_OFF = 2'h3
  } net_cmd_t;

  typedef struct packed {
    logic     valid;
    net_cmd_t cmd;
  } net_req_t;

  typedef struct packed {
    logic in_msg;
    logic out_q;
    logic opc;
    logic wait_abort;
  } clear_act_t;
endpackage : gpib_rl_pkg

//--- hdl/gpib_remote_local_control.sv
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/10ps
// How it works
// - Own bus address 0..30, respond only there
// - Command set change applies at next power-up
// - Legacy set rejects standard commands, network
// - Interface clear idles talker, listener, halts sending
// - Remote enable line moves remote and local
// - Parallel poll, take control ignored
// - Go-to-local while listener enters local mode
// - Selected clear drops input message, output queue
// - Device clear drops pending OPC, aborts waits
// - Legacy trigger reports configuration and status
// - Local lockout blocks output switch to local
// - Universal clear does same as selected clear
// - Serial poll enable puts talker in poll
// - Serial poll disable leaves poll mode
// - Selected clear needs addressing, universal does not
// - Network remote on enters remote, lights lamp
// - Remote disables panel except output switch
// - Output switch to local unless lockout
// - Network remote off goes local despite lockout
// - Mode change keeps all settings unchanged
module gpib_remote_local_control (
  // Clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_nrst,
  // Wishbone slave
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [7:0]              i_wb_adr,
  input  wire logic [31:0]             i_wb_dat,
  input  wire logic [3:0]              i_wb_sel,
  output logic      [31:0]             o_wb_dat,
  output logic                         o_wb_ack,
  // Bus pins, asserted high, asynchronous
  input  wire logic                    i_atn,
  input  wire logic                    i_ifc,
  input  wire logic                    i_ren,
  input  wire logic                    i_dav,
  input  wire logic [7:0]              i_dio,
  // Front panel and stored command set, asynchronous
  input  wire logic                    i_sw_local,
  input  wire logic                    i_nv_legacy,
  // Network command path, core clock
  input  wire gpib_rl_pkg::net_req_t   i_net_req,
  // Mode and action outputs
  output logic                         o_remote_lamp,
  output logic                         o_panel_enable,
  output logic                         o_lockout,
  output logic                         o_listen,
  output logic                         o_talk,
  output logic                         o_spoll,
  output logic                         o_halt_tx,
  output gpib_rl_pkg::clear_act_t      o_clear,
  output logic                         o_trig_report,
  output logic                         o_std_reject,
  output logic                         o_net_enable,
  output logic                         o_nv_legacy_sel
);

  // Synchronisers for everything that arrives from pins
  logic [13:0] sync1_ff;
  logic [13:0] sync2_ff;
  logic        dav_d_ff;
  logic        ren_d_ff;
  logic        sw_d_ff;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_ff <= 14'h0000;
      sync2_ff <= 14'h0000;
      dav_d_ff <= 1'b0;
      ren_d_ff <= 1'b0;
      sw_d_ff  <= 1'b0;
    end else begin
      sync1_ff <= {i_nv_legacy, i_sw_local, i_dav, i_ren, i_ifc, i_atn, i_dio};
      sync2_ff <= sync1_ff;
      dav_d_ff <= sync2_ff[11];
      ren_d_ff <= sync2_ff[10];
      sw_d_ff  <= sync2_ff[12];
    end
  end

  wire       atn_s    = sync2_ff[8];
  wire       ifc_s    = sync2_ff[9];
  wire       ren_s    = sync2_ff[10];
  wire       dav_s    = sync2_ff[11];
  wire       sw_s     = sync2_ff[12];
  wire       nv_s     = sync2_ff[13];
  wire [6:0] cmd_byte = sync2_ff[6:0];

  // Registers
  logic [4:0] addr_ff;
  logic       set_sel_ff;
  logic       legacy_ff;
  logic       net_en_ff;
  logic [1:0] boot_ff;
  logic       remote_ff;
  logic       lockout_ff;
  logic       listen_ff;
  logic       talk_ff;
  logic       spoll_ff;
  logic       ack_ff;
  logic [31:0] rdat_ff;
  logic       halt_ff;
  logic       trig_ff;
  logic       panel_ff;
  gpib_rl_pkg::clear_act_t clear_ff;

  // Command decode; interface clear masks every byte
  wire booted   = (boot_ff == gpib_rl_pkg::BOOT_DONE);
  wire take     = atn_s && dav_s && !dav_d_ff && !ifc_s;
  wire is_mla   = take && (cmd_byte == {gpib_rl_pkg::GRP_LISTEN, addr_ff});
  wire is_mta   = take && (cmd_byte == {gpib_rl_pkg::GRP_TALK, addr_ff});
  wire is_ota   = take && (cmd_byte[6:5] == gpib_rl_pkg::GRP_TALK) && !is_mta;
  wire is_unl   = take && (cmd_byte == gpib_rl_pkg::CMD_UNL);
  wire is_unt   = take && (cmd_byte == gpib_rl_pkg::CMD_UNT);
  wire is_gtl   = take && (cmd_byte == gpib_rl_pkg::CMD_GTL) && listen_ff;
  wire is_sdc   = take && (cmd_byte == gpib_rl_pkg::CMD_SDC) && listen_ff;
  wire is_get   = take && (cmd_byte == gpib_rl_pkg::CMD_GET) && listen_ff;
  wire is_llo   = take && (cmd_byte == gpib_rl_pkg::CMD_LLO);
  wire is_dcl   = take && (cmd_byte == gpib_rl_pkg::CMD_DCL);
  wire is_spe   = take && (cmd_byte == gpib_rl_pkg::CMD_SPE);
  wire is_spd   = take && (cmd_byte == gpib_rl_pkg::CMD_SPD);
  // Poll configure, unconfigure and take control are decoded but drive no action
  wire is_ign   = take && ((cmd_byte == gpib_rl_pkg::CMD_PPC) ||
                           (cmd_byte == gpib_rl_pkg::CMD_PPU) ||
                           (cmd_byte == gpib_rl_pkg::CMD_TCT));
  wire dev_clr  = is_sdc || is_dcl;

  // Network path is dead while the legacy set is active
  wire net_ok   = i_net_req.valid && !legacy_ff;
  wire net_on   = net_ok && (i_net_req.cmd == gpib_rl_pkg::NET_REM_ON);
  wire net_off  = net_ok && (i_net_req.cmd == gpib_rl_pkg::NET_REM_OFF);
  wire net_lon  = net_ok && (i_net_req.cmd == gpib_rl_pkg::NET_LOCK_ON);
  wire net_loff = net_ok && (i_net_req.cmd == gpib_rl_pkg::NET_LOCK_OFF);

  wire ren_fall = ren_d_ff && !ren_s;
  wire sw_edge  = sw_s && !sw_d_ff;

  // Remote and lockout next state; later lines take priority
  logic nxt_remote;
  logic nxt_lockout;
  always_comb begin
    nxt_remote  = remote_ff;
    nxt_lockout = lockout_ff;
    if (is_mla && ren_s) begin
      nxt_remote = 1'b1;
    end
    if (is_llo && ren_s) begin
      nxt_lockout = 1'b1;
    end
    if (net_lon) begin
      nxt_lockout = 1'b1;
    end
    if (net_loff) begin
      nxt_lockout = 1'b0;
    end
    if (net_on) begin
      nxt_remote = 1'b1;
    end
    if (sw_edge && remote_ff && !lockout_ff) begin
      nxt_remote = 1'b0;
    end
    if (is_gtl) begin
      nxt_remote = 1'b0;
    end
    if (net_off) begin
      nxt_remote = 1'b0;
    end
    if (ren_fall) begin
      nxt_remote  = 1'b0;
      nxt_lockout = 1'b0;
    end
  end

  // Talker and listener addressing
  logic nxt_listen;
  logic nxt_talk;
  logic nxt_spoll;
  always_comb begin
    nxt_listen = listen_ff;
    nxt_talk   = talk_ff;
    nxt_spoll  = spoll_ff;
    if (is_mla) begin
      nxt_listen = 1'b1;
      nxt_talk   = 1'b0;
    end
    if (is_mta) begin
      nxt_talk   = 1'b1;
      nxt_listen = 1'b0;
    end
    if (is_ota || is_unt) begin
      nxt_talk = 1'b0;
    end
    if (is_unl) begin
      nxt_listen = 1'b0;
    end
    if (is_spe) begin
      nxt_spoll = 1'b1;
    end
    if (is_spd) begin
      nxt_spoll = 1'b0;
    end
    if (ifc_s) begin
      nxt_listen = 1'b0;
      nxt_talk   = 1'b0;
      nxt_spoll  = 1'b0;
    end
  end

  // Mode flops; switching mode drives no clear or setting action
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      remote_ff  <= 1'b0;
      lockout_ff <= 1'b0;
      listen_ff  <= 1'b0;
      talk_ff    <= 1'b0;
      spoll_ff   <= 1'b0;
      panel_ff   <= 1'b1;
    end else begin
      remote_ff  <= nxt_remote;
      lockout_ff <= nxt_lockout;
      listen_ff  <= nxt_listen;
      talk_ff    <= nxt_talk;
      spoll_ff   <= nxt_spoll;
      panel_ff   <= !nxt_remote;
    end
  end

  // One-cycle clear and trigger strobes; halt follows interface clear
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clear_ff <= '0;
      trig_ff  <= 1'b0;
      halt_ff  <= 1'b0;
    end else begin
      clear_ff.in_msg     <= dev_clr;
      clear_ff.out_q      <= dev_clr;
      clear_ff.opc        <= dev_clr;
      clear_ff.wait_abort <= dev_clr;
      trig_ff             <= is_get && legacy_ff;
      halt_ff             <= ifc_s;
    end
  end

  // Stored set is sampled once after release; later writes only
  // change the value handed to storage for the next power-up
  wire wr_now = i_wb_cyc && i_wb_stb && i_wb_we && ack_ff;
  wire cfg_wr = wr_now && (i_wb_adr == gpib_rl_pkg::CFG_OFS);
  wire [4:0] wr_addr = i_wb_dat[gpib_rl_pkg::CFG_ADDR_LSB +: 5];
  wire addr_ok = cfg_wr && i_wb_sel[0] && (wr_addr <= gpib_rl_pkg::ADDR_MAX);
  wire set_wr  = cfg_wr && i_wb_sel[1];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      boot_ff    <= 2'h0;
      legacy_ff  <= gpib_rl_pkg::SET_RST;
      net_en_ff  <= 1'b1;
      set_sel_ff <= gpib_rl_pkg::SET_RST;
      addr_ff    <= gpib_rl_pkg::ADDR_RST;
    end else begin
      if (!booted) begin
        boot_ff <= boot_ff + 2'h1;
      end
      if (boot_ff == gpib_rl_pkg::BOOT_DONE - 2'h1) begin
        legacy_ff  <= nv_s;
        net_en_ff  <= !nv_s;
        set_sel_ff <= nv_s;
      end else if (set_wr) begin
        set_sel_ff <= i_wb_dat[gpib_rl_pkg::CFG_SET_BIT];
      end
      if (addr_ok) begin
        addr_ff <= wr_addr;
      end
    end
  end

  // Wishbone: ack one cycle after the request, write at the ack edge
  wire req = i_wb_cyc && i_wb_stb && !ack_ff;
  logic [31:0] cfg_word;
  logic [31:0] stat_word;
  logic [31:0] rd_mux;
  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[gpib_rl_pkg::CFG_ADDR_LSB +: 5] = addr_ff;
    cfg_word[gpib_rl_pkg::CFG_SET_BIT]       = set_sel_ff;
    stat_word = 32'h0000_0000;
    stat_word[gpib_rl_pkg::ST_REMOTE]  = remote_ff;
    stat_word[gpib_rl_pkg::ST_LOCKOUT] = lockout_ff;
    stat_word[gpib_rl_pkg::ST_LISTEN]  = listen_ff;
    stat_word[gpib_rl_pkg::ST_TALK]    = talk_ff;
    stat_word[gpib_rl_pkg::ST_SPOLL]   = spoll_ff;
    stat_word[gpib_rl_pkg::ST_LEGACY]  = legacy_ff;
    stat_word[gpib_rl_pkg::ST_PENDING] = set_sel_ff ^ legacy_ff;
    case (i_wb_adr)
      gpib_rl_pkg::CFG_OFS:  rd_mux = cfg_word;
      gpib_rl_pkg::STAT_OFS: rd_mux = stat_word;
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_ff  <= 1'b0;
      rdat_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= req;
      if (req) begin
        rdat_ff <= rd_mux;
      end
    end
  end

  assign o_wb_ack        = ack_ff;
  assign o_wb_dat        = rdat_ff;
  assign o_remote_lamp   = remote_ff;
  assign o_panel_enable  = panel_ff;
  assign o_lockout       = lockout_ff;
  assign o_listen        = listen_ff;
  assign o_talk          = talk_ff;
  assign o_spoll         = spoll_ff;
  assign o_halt_tx       = halt_ff;
  assign o_clear         = clear_ff;
  assign o_trig_report   = trig_ff;
  assign o_std_reject    = legacy_ff;
  assign o_net_enable    = net_en_ff;
  assign o_nv_legacy_sel = set_sel_ff;

  // Checks
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  a_addr_in_range: assert property (addr_ff <= gpib_rl_pkg::ADDR_MAX)
    else $error("bus address above 30");

  a_set_deferred: assert property (booted && $past(booted) |->
    $stable(legacy_ff))
    else $error("active command set changed after power-up");

  a_legacy_net_dead: assert property (legacy_ff && i_net_req.valid &&
    !take && !ren_fall && !sw_edge |=> $stable(remote_ff) && !o_net_enable)
    else $error("network command acted on in legacy mode");

  a_ifc_idles: assert property (ifc_s |=> !listen_ff && !talk_ff &&
    o_halt_tx)
    else $error("interface clear did not idle talker and listener");

  a_gtl_local: assert property (is_gtl |=> !remote_ff)
    else $error("go-to-local left device remote");

  a_clear_all: assert property (is_dcl || is_sdc |=>
    o_clear.in_msg && o_clear.out_q && o_clear.opc && o_clear.wait_abort
    ##1 o_clear == '0)
    else $error("device clear strobes wrong");

  a_ignored_msgs: assert property (is_ign |=> $stable(remote_ff) &&
    $stable(listen_ff) && $stable(spoll_ff) && o_clear == '0)
    else $error("ignored message changed state");

  a_lockout_holds: assert property (remote_ff && lockout_ff && sw_edge &&
    !net_off && !ren_fall && !is_gtl |=> remote_ff)
    else $error("output switch left remote under lockout");

  a_net_off_local: assert property (net_off |=> !remote_ff &&
    o_panel_enable)
    else $error("network remote off did not return to local");

  a_spoll_mode: assert property (is_spe |=> spoll_ff [*1] ##0
    o_spoll)
    else $error("serial poll enable not taken");

  a_sdc_unaddr: assert property (take && !listen_ff &&
    cmd_byte == gpib_rl_pkg::CMD_SDC |=> o_clear == '0)
    else $error("selected clear acted while unaddressed");

  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");

  c_net_remote: cover property (net_on ##1 remote_ff ##[1:40] net_off);
  c_lockout_sw: cover property (lockout_ff && remote_ff && sw_edge);
  c_dev_clear: cover property (is_dcl ##1 o_clear.in_msg);
  c_legacy_get: cover property (is_get && legacy_ff);

endmodule : gpib_remote_local_control

//--- tb/gpib_controller_model.sv
`timescale 1ns/10ps
module gpib_controller_model (
  // Clock
  input  wire logic             i_core_clk,
  // Bus lines towards the instrument
  output logic                  o_atn,
  output logic                  o_ifc,
  output logic                  o_ren,
  output logic                  o_dav,
  output logic [7:0]            o_dio,
  // Network command path
  output gpib_rl_pkg::net_req_t o_net_req
);
  // Settle time after a command, scaled far below the real wait
  localparam int SETTLE_CYC = 4;

  initial begin
    o_atn     = 1'b0;
    o_ifc     = 1'b0;
    o_ren     = 1'b0;
    o_dav     = 1'b0;
    o_dio     = 8'h00;
    o_net_req = '0;
  end

  // One byte at a time; the network path is never used meanwhile
  task automatic send_cmd(input logic [7:0] b);
    @(posedge i_core_clk);
    o_atn <= 1'b1;
    o_dio <= b;
    o_dav <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    o_dav <= 1'b0;
    // A released data bus must not look like the last byte
    o_dio <= ~b;
    o_atn <= 1'b0;
    repeat (SETTLE_CYC) @(posedge i_core_clk);
  endtask : send_cmd

  task automatic send_net(input gpib_rl_pkg::net_cmd_t c);
    @(posedge i_core_clk);
    o_net_req <= '{valid: 1'b1, cmd: c};
    @(posedge i_core_clk);
    o_net_req.valid <= 1'b0;
  endtask : send_net

  task automatic set_ctl(input logic ren, input logic ifc);
    @(posedge i_core_clk);
    o_ren <= ren;
    o_ifc <= ifc;
  endtask : set_ctl
endmodule : gpib_controller_model

//--- tb/gpib_remote_local_control_test.sv
`timescale 1ns/10ps
module gpib_remote_local_control_test;
  logic                    clk;
  logic                    nrst;
  logic                    cyc;
  logic                    stb;
  logic                    we;
  logic [7:0]              adr;
  logic [31:0]             wdat;
  logic [3:0]              sel;
  logic [31:0]             rdat;
  logic                    ack;
  logic                    atn;
  logic                    ifc;
  logic                    ren;
  logic                    dav;
  logic [7:0]              dio;
  logic                    sw;
  logic                    nv;
  gpib_rl_pkg::net_req_t   nreq;
  logic                    lamp;
  logic                    panel;
  logic                    lock;
  logic                    listen;
  logic                    talk;
  logic                    spoll;
  logic                    halt;
  gpib_rl_pkg::clear_act_t clr;
  logic                    trig;
  logic                    reject;
  logic                    net_en;
  logic                    nv_sel;
  logic [31:0]             q;
  int                      bad_count;
  int                      comparisons;
  int                      cycles;
  int                      clr_cnt;
  int                      clr_odd;
  int                      trig_cnt;
  int                      c;

  gpib_remote_local_control u_gpib_remote_local_control (
    .i_core_clk(clk), .i_nrst(nrst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_atn(atn), .i_ifc(ifc),
    .i_ren(ren), .i_dav(dav), .i_dio(dio), .i_sw_local(sw),
    .i_nv_legacy(nv), .i_net_req(nreq), .o_remote_lamp(lamp),
    .o_panel_enable(panel), .o_lockout(lock), .o_listen(listen),
    .o_talk(talk), .o_spoll(spoll), .o_halt_tx(halt), .o_clear(clr),
    .o_trig_report(trig), .o_std_reject(reject), .o_net_enable(net_en),
    .o_nv_legacy_sel(nv_sel));

  gpib_controller_model u_gpib_controller_model (
    .i_core_clk(clk), .o_atn(atn), .o_ifc(ifc), .o_ren(ren),
    .o_dav(dav), .o_dio(dio), .o_net_req(nreq));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Strobes last one cycle, so they are counted at every edge
  always @(posedge clk) begin
    cycles++;
    if (nrst && clr === 4'hf) clr_cnt++;
    else if (nrst && clr !== 4'h0) clr_odd++;
    if (nrst && trig === 1'b1) trig_cnt++;
    if (cycles == 5000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cyc

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask : wb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string nm);
    wb(1'b0, a, 32'h0, 4'hf);
    chk(nm, e, q);
  endtask : rd_chk

  task automatic bc(input logic [6:0] b);
    u_gpib_controller_model.send_cmd({1'b0, b});
    wait_cyc(2);
  endtask : bc

  task automatic net(input gpib_rl_pkg::net_cmd_t n);
    u_gpib_controller_model.send_net(n);
    wait_cyc(1);
  endtask : net

  task automatic flip;
    @(posedge clk);
    sw <= 1'b1;
    wait_cyc(6);
    @(posedge clk);
    sw <= 1'b0;
    wait_cyc(4);
  endtask : flip

  task automatic do_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    wait_cyc(5);
  endtask : do_reset

  task automatic t_config;
    chk("panel", 1, panel);
    chk("net_en", 1, net_en);
    rd_chk(gpib_rl_pkg::CFG_OFS, 32'h01, "cfg_rst");
    wb(1'b1, gpib_rl_pkg::CFG_OFS, 32'h1f, 4'h1);
    rd_chk(gpib_rl_pkg::CFG_OFS, 32'h01, "cfg_31");
    wb(1'b1, gpib_rl_pkg::CFG_OFS, 32'h1e, 4'h1);
    rd_chk(gpib_rl_pkg::CFG_OFS, 32'h1e, "cfg_30");
    wb(1'b1, gpib_rl_pkg::STAT_OFS, 32'hff, 4'hf);
    rd_chk(gpib_rl_pkg::STAT_OFS, 32'h0, "stat_ro");
    rd_chk(8'h08, 32'h0, "unmapped");
  endtask : t_config

  task automatic t_address;
    u_gpib_controller_model.set_ctl(1'b1, 1'b0);
    bc(7'h21);
    chk("other_adr", 0, lamp);
    bc(7'h3e);
    chk("own_adr", 1, lamp);
    chk("panel_off", 0, panel);
    chk("listen", 1, listen);
  endtask : t_address

  task automatic t_ignored;
    c = clr_cnt + trig_cnt;
    bc(gpib_rl_pkg::CMD_PPC);
    bc(gpib_rl_pkg::CMD_PPU);
    bc(gpib_rl_pkg::CMD_TCT);
    chk("ign_strobes", c, clr_cnt + trig_cnt);
    chk("ign_state", 6'h03, {talk, spoll, lock, 1'b0, listen, lamp});
  endtask : t_ignored

  task automatic t_clear;
    c = clr_cnt;
    bc(gpib_rl_pkg::CMD_SDC);
    chk("sdc", c + 1, clr_cnt);
    bc(gpib_rl_pkg::CMD_UNL);
    bc(gpib_rl_pkg::CMD_SDC);
    chk("sdc_unaddr", c + 1, clr_cnt);
    bc(gpib_rl_pkg::CMD_DCL);
    chk("dcl", c + 2, clr_cnt);
    chk("clr_fields", 0, clr_odd);
  endtask : t_clear

  task automatic t_gtl;
    bc(gpib_rl_pkg::CMD_GTL);
    chk("gtl_unaddr", 1, lamp);
    bc(7'h3e);
    bc(gpib_rl_pkg::CMD_GTL);
    chk("gtl", 0, lamp);
    chk("panel_on", 1, panel);
    rd_chk(gpib_rl_pkg::CFG_OFS, 32'h1e, "cfg_kept");
  endtask : t_gtl

  task automatic t_lockout;
    bc(7'h3e);
    flip();
    chk("sw_local", 0, lamp);
    bc(7'h3e);
    bc(gpib_rl_pkg::CMD_LLO);
    chk("llo", 1, lock);
    flip();
    chk("sw_locked", 1, lamp);
    u_gpib_controller_model.set_ctl(1'b0, 1'b0);
    wait_cyc(6);
    chk("ren_off", 2'h0, {lock, lamp});
  endtask : t_lockout

  task automatic t_spoll;
    bc(gpib_rl_pkg::CMD_SPE);
    chk("spe", 1, spoll);
    bc(gpib_rl_pkg::CMD_SPD);
    chk("spd", 0, spoll);
    bc(7'h5e);
    chk("mta", 2'h2, {talk, listen});
    bc(gpib_rl_pkg::CMD_UNT);
    chk("unt", 0, talk);
  endtask : t_spoll

  task automatic t_ifc;
    u_gpib_controller_model.set_ctl(1'b1, 1'b0);
    bc(7'h3e);
    u_gpib_controller_model.set_ctl(1'b1, 1'b1);
    wait_cyc(4);
    chk("ifc_halt", 1, halt);
    chk("ifc_idle", 0, listen);
    c = clr_cnt;
    bc(gpib_rl_pkg::CMD_DCL);
    chk("ifc_byte", c, clr_cnt);
    u_gpib_controller_model.set_ctl(1'b0, 1'b0);
    wait_cyc(6);
    chk("ifc_end", 0, halt);
  endtask : t_ifc

  task automatic t_net;
    net(gpib_rl_pkg::NET_REM_ON);
    chk("net_on", 2'h1, {panel, lamp});
    net(gpib_rl_pkg::NET_LOCK_ON);
    flip();
    chk("net_locked", 1, lamp);
    net(gpib_rl_pkg::NET_REM_OFF);
    chk("net_off", 0, lamp);
    net(gpib_rl_pkg::NET_LOCK_OFF);
    chk("lock_off", 0, lock);
  endtask : t_net

  task automatic t_legacy;
    wb(1'b1, gpib_rl_pkg::CFG_OFS, 32'h11e, 4'h3);
    wait_cyc(2);
    chk("set_later", 3'h6, {nv_sel, net_en, reject});
    rd_chk(gpib_rl_pkg::STAT_OFS, 32'h1 << gpib_rl_pkg::ST_PENDING,
           "pending");
    @(posedge clk);
    nv <= 1'b1;
    do_reset();
    chk("legacy", 2'h2, {reject, net_en});
    net(gpib_rl_pkg::NET_REM_ON);
    chk("net_refused", 0, lamp);
    u_gpib_controller_model.set_ctl(1'b1, 1'b0);
    bc(7'h21);
    c = trig_cnt;
    bc(gpib_rl_pkg::CMD_GET);
    chk("get", c + 1, trig_cnt);
    bc(gpib_rl_pkg::CMD_UNL);
    bc(gpib_rl_pkg::CMD_GET);
    chk("get_unaddr", c + 1, trig_cnt);
  endtask : t_legacy

  initial begin
    nrst = 1'b0;
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 8'h00;
    wdat = 32'h0;
    sel  = 4'h0;
    sw   = 1'b0;
    nv   = 1'b0;
    do_reset();
    t_config();
    t_address();
    t_ignored();
    t_clear();
    t_gtl();
    t_lockout();
    t_spoll();
    t_ifc();
    t_net();
    t_legacy();
    summarize();
  end
endmodule : gpib_remote_local_control_test
